// file: pkg/gtimer_pkg.sv
// Purpose: shared constants for the timer group
// Assumes: 16-bit register port, one clock
// Notes: offsets are word indexes on the plain register port
package gtimer_pkg;
    localparam int MAIN_W = 16;
    localparam int AUX_W = 8;
    localparam int NCH = 5;
    localparam int ADDR_W = 6;
    localparam int DATA_W = 16;
    // ************************************
    // register offsets
    // ************************************
    localparam logic [5:0] OFF_MAIN_CTRL = 6'h00;
    localparam logic [5:0] OFF_MAIN_PRE = 6'h01;
    localparam logic [5:0] OFF_MAIN_PER = 6'h02;
    localparam logic [5:0] OFF_MAIN_CNT = 6'h03;
    localparam logic [5:0] OFF_CH_CTRL = 6'h04;
    localparam logic [5:0] OFF_CH_VAL = 6'h08;
    localparam logic [5:0] OFF_AUXA_CTRL = 6'h10;
    localparam logic [5:0] OFF_AUXA_PRE = 6'h11;
    localparam logic [5:0] OFF_AUXA_PER = 6'h12;
    localparam logic [5:0] OFF_AUXA_CMP = 6'h13;
    localparam logic [5:0] OFF_AUXA_CNT = 6'h14;
    localparam logic [5:0] OFF_AUXB_CTRL = 6'h18;
    localparam logic [5:0] OFF_AUXB_PRE = 6'h19;
    localparam logic [5:0] OFF_AUXB_PER = 6'h1A;
    localparam logic [5:0] OFF_AUXB_CMP = 6'h1B;
    localparam logic [5:0] OFF_AUXB_CNT = 6'h1C;
    localparam logic [5:0] OFF_STATUS = 6'h20;
    localparam logic [5:0] OFF_MASK = 6'h21;
    localparam logic [5:0] OFF_DMA_EN = 6'h22;
    // ************************************
    // field positions
    // ************************************
    localparam int MC_RUN = 0;
    localparam int MC_MODE_LO = 1;
    localparam int MC_IR = 3;
    localparam int CC_MODE = 0;
    localparam int CC_EDGE_LO = 1;
    localparam int AC_RUN = 0;
    localparam int ST_MAIN_OVF = 0;
    localparam int ST_CH_LO = 1;
    localparam int ST_AUXA_OVF = 6;
    localparam int ST_AUXA_CMP = 7;
    localparam int ST_AUXB_OVF = 8;
    localparam int ST_AUXB_CMP = 9;
    localparam int NSTAT = 10;
    // ************************************
    // reset values
    // ************************************
    localparam logic [15:0] RST_PER16 = 16'hFFFF;
    localparam logic [7:0] RST_PER8 = 8'hFF;
    localparam logic [15:0] RST_ZERO16 = 16'h0000;
    localparam logic [7:0] RST_ZERO8 = 8'h00;
    typedef enum logic [1:0] {
        MODE_STOP = 2'b00,
        MODE_FREE = 2'b01,
        MODE_EVENT = 2'b10,
        MODE_PWM = 2'b11
    } main_mode_type;
endpackage

// file: logic/gtimer_prescaler.sv
// Purpose: programmable tick divider
// Assumes: div value N gives one tick every N+1 clocks
// Notes: held in reset while disabled
module gtimer_prescaler import gtimer_pkg::*; #(
    parameter int W = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic en,
    input wire logic [W-1:0] div,
    output logic tick
);
    logic [W-1:0] cnt_r;
    logic [W-1:0] cnt_nxt;

    always_comb begin
        cnt_nxt = cnt_r;
        tick = 1'b0;
        if (!en) begin
            cnt_nxt = '0;
        end else if (cnt_r >= div) begin
            cnt_nxt = '0;
            tick = 1'b1;
        end else begin
            cnt_nxt = cnt_r + 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end
endmodule // gtimer_prescaler

// file: logic/gtimer_aux.sv
// Purpose: 8-bit auxiliary timer with one compare channel
// Assumes: tick from a prescaler on the same clock
// Notes: pwm high while count below compare
module gtimer_aux import gtimer_pkg::*; #(
    parameter int W = AUX_W
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic run,
    input wire logic tick,
    input wire logic [W-1:0] period,
    input wire logic [W-1:0] cmp,
    output logic [W-1:0] count,
    output logic pwm,
    output logic ovf,
    output logic match
);
    logic [W-1:0] cnt_r;
    logic [W-1:0] cnt_nxt;
    logic pwm_r;
    logic pwm_nxt;

    always_comb begin
        cnt_nxt = cnt_r;
        ovf = 1'b0;
        match = 1'b0;
        if (!run) begin
            cnt_nxt = '0;
        end else if (tick) begin
            match = (cnt_r == cmp);
            if (cnt_r >= period) begin
                cnt_nxt = '0;
                ovf = 1'b1;
            end else begin
                cnt_nxt = cnt_r + 1'b1;
            end
        end
        pwm_nxt = run && (cnt_nxt < cmp);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r <= '0;
            pwm_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            pwm_r <= pwm_nxt;
        end
    end

    assign count = cnt_r;
    assign pwm = pwm_r;
endmodule // gtimer_aux

// file: logic/gtimer_top.sv
// Purpose: timer group: 16-bit main timer with five channels, two 8-bit aux timers
// Assumes: plain register port, 16-bit data, read data one cycle after strobe
// Notes: capture pins are synchronised by two flops
// ************************************
// ************************************
module gtimer_top import gtimer_pkg::*; (
    input wire logic CLK,
    input wire logic RST,
    input wire logic [ADDR_W-1:0] ADDR,
    input wire logic [DATA_W-1:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [DATA_W-1:0] RDATA,
    input wire logic EVENT_IN,
    input wire logic [NCH-1:0] CAP_IN,
    output logic [NCH-1:0] CH_OUT,
    output logic [NCH-1:0] CH_OE,
    output logic AUXA_OUT,
    output logic AUXB_OUT,
    output logic IR_OUT,
    output logic [2:0] DMA_REQ,
    output logic IRQ
);
    // ************************************
    // registers
    // ************************************
    logic [3:0] mctrl_r, mctrl_nxt;
    logic [15:0] mpre_r, mpre_nxt, mper_r, mper_nxt, mcnt_r, mcnt_nxt;
    logic [2:0] cctrl_r [NCH];
    logic [2:0] cctrl_nxt [NCH];
    logic [15:0] cval_r [NCH];
    logic [15:0] cval_nxt [NCH];
    logic [0:0] actrl_r [2];
    logic [0:0] actrl_nxt [2];
    logic [7:0] apre_r [2];
    logic [7:0] apre_nxt [2];
    logic [7:0] aper_r [2];
    logic [7:0] aper_nxt [2];
    logic [7:0] acmp_r [2];
    logic [7:0] acmp_nxt [2];
    logic [NSTAT-1:0] stat_r, stat_nxt, mask_r, mask_nxt;
    logic [2:0] dmaen_r, dmaen_nxt;
    logic [DATA_W-1:0] rdata_r, rdata_nxt;
    logic [NCH-1:0] chout_r, chout_nxt;
    logic [NCH-1:0] cap_s1_r, cap_s2_r, cap_d_r;
    logic ev_s1_r, ev_s2_r, ev_d_r;
    logic [2:0] dreq_r, dreq_nxt;

    // ************************************
    // aux timers
    // ************************************
    logic [1:0] a_tick, a_ovf, a_match, a_pwm;
    logic [7:0] a_cnt [2];

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_aux
            gtimer_prescaler #(.W(AUX_W)) u_pre (
                .clk(CLK),
                .rst(RST),
                .en(actrl_r[g][AC_RUN]),
                .div(apre_r[g]),
                .tick(a_tick[g])
            );
            gtimer_aux #(.W(AUX_W)) u_aux (
                .clk(CLK),
                .rst(RST),
                .run(actrl_r[g][AC_RUN]),
                .tick(a_tick[g]),
                .period(aper_r[g]),
                .cmp(acmp_r[g]),
                .count(a_cnt[g]),
                .pwm(a_pwm[g]),
                .ovf(a_ovf[g]),
                .match(a_match[g])
            );
        end
    endgenerate

    // ************************************
    // main timer tick source
    // ************************************
    main_mode_type mmode;
    logic m_run, ir_mode, m_pre_tick, m_tick, m_ovf, ev_edge;
    logic [NCH-1:0] cap_edge, ch_match;

    assign mmode = main_mode_type'(mctrl_r[MC_MODE_LO+1:MC_MODE_LO]);
    assign m_run = mctrl_r[MC_RUN] && (mmode != MODE_STOP);
    assign ir_mode = mctrl_r[MC_IR];
    assign ev_edge = ev_s2_r && !ev_d_r;

    gtimer_prescaler #(.W(MAIN_W)) u_mpre (
        .clk(CLK),
        .rst(RST),
        .en(m_run),
        .div(mpre_r),
        .tick(m_pre_tick)
    );

    // ir mode steps once per aux A period; event mode once per rising input edge
    always_comb begin
        if (ir_mode) begin
            m_tick = m_run && a_ovf[0];
        end else if (mmode == MODE_EVENT) begin
            m_tick = m_run && ev_edge;
        end else begin
            m_tick = m_pre_tick;
        end
    end

    // decode of a channel's capture edge select: 01 rise, 10 fall, 11 both
    function automatic logic edge_hit(input logic [1:0] sel, input logic now, input logic prev);
        edge_hit = (sel[0] && now && !prev) || (sel[1] && !now && prev);
    endfunction

    // ************************************
    // counter, channels, flags
    // ************************************
    always_comb begin
        mcnt_nxt = mcnt_r;
        m_ovf = 1'b0;
        if (!m_run) begin
            mcnt_nxt = RST_ZERO16;
        end else if (m_tick) begin
            if (mcnt_r >= mper_r) begin
                mcnt_nxt = RST_ZERO16;
                m_ovf = 1'b1;
            end else begin
                mcnt_nxt = mcnt_r + 16'h0001;
            end
        end
        for (int i = 0; i < NCH; i++) begin
            cap_edge[i] = cctrl_r[i][CC_MODE] && m_run &&
                          edge_hit(cctrl_r[i][CC_EDGE_LO+1:CC_EDGE_LO], cap_s2_r[i], cap_d_r[i]);
            ch_match[i] = !cctrl_r[i][CC_MODE] && m_tick && (mcnt_r == cval_r[i]);
            chout_nxt[i] = !cctrl_r[i][CC_MODE] && m_run && (mcnt_nxt < cval_r[i]);
        end
    end

    // ************************************
    // register file
    // ************************************
    logic [NSTAT-1:0] ev_set;
    assign ev_set = {a_match[1], a_ovf[1], a_match[0], a_ovf[0], cap_edge | ch_match, m_ovf};

    always_comb begin
        mctrl_nxt = mctrl_r;
        mpre_nxt = mpre_r;
        mper_nxt = mper_r;
        actrl_nxt = actrl_r;
        apre_nxt = apre_r;
        aper_nxt = aper_r;
        acmp_nxt = acmp_r;
        cctrl_nxt = cctrl_r;
        cval_nxt = cval_r;
        mask_nxt = mask_r;
        dmaen_nxt = dmaen_r;
        stat_nxt = stat_r;
        rdata_nxt = '0;
        for (int i = 0; i < NCH; i++) begin
            if (cap_edge[i]) begin
                cval_nxt[i] = mcnt_r;
            end
        end
        if (WR) begin
            case (ADDR)
                OFF_MAIN_CTRL: mctrl_nxt = WDATA[3:0];
                OFF_MAIN_PRE: mpre_nxt = WDATA;
                OFF_MAIN_PER: mper_nxt = WDATA;
                OFF_AUXA_CTRL: actrl_nxt[0] = WDATA[0:0];
                OFF_AUXA_PRE: apre_nxt[0] = WDATA[7:0];
                OFF_AUXA_PER: aper_nxt[0] = WDATA[7:0];
                OFF_AUXA_CMP: acmp_nxt[0] = WDATA[7:0];
                OFF_AUXB_CTRL: actrl_nxt[1] = WDATA[0:0];
                OFF_AUXB_PRE: apre_nxt[1] = WDATA[7:0];
                OFF_AUXB_PER: aper_nxt[1] = WDATA[7:0];
                OFF_AUXB_CMP: acmp_nxt[1] = WDATA[7:0];
                OFF_MASK: mask_nxt = WDATA[NSTAT-1:0];
                OFF_DMA_EN: dmaen_nxt = WDATA[2:0];
                default: begin
                    for (int i = 0; i < NCH; i++) begin
                        if (ADDR == OFF_CH_CTRL + 6'(i)) begin
                            cctrl_nxt[i] = WDATA[2:0];
                        end
                        if (ADDR == OFF_CH_VAL + 6'(i)) begin
                            cval_nxt[i] = WDATA;
                        end
                    end
                end
            endcase
        end
        if (RD) begin
            case (ADDR)
                OFF_MAIN_CTRL: rdata_nxt = {12'h000, mctrl_r};
                OFF_MAIN_PRE: rdata_nxt = mpre_r;
                OFF_MAIN_PER: rdata_nxt = mper_r;
                OFF_MAIN_CNT: rdata_nxt = mcnt_r;
                OFF_AUXA_CTRL: rdata_nxt = {15'h0000, actrl_r[0]};
                OFF_AUXA_PRE: rdata_nxt = {8'h00, apre_r[0]};
                OFF_AUXA_PER: rdata_nxt = {8'h00, aper_r[0]};
                OFF_AUXA_CMP: rdata_nxt = {8'h00, acmp_r[0]};
                OFF_AUXA_CNT: rdata_nxt = {8'h00, a_cnt[0]};
                OFF_AUXB_CTRL: rdata_nxt = {15'h0000, actrl_r[1]};
                OFF_AUXB_PRE: rdata_nxt = {8'h00, apre_r[1]};
                OFF_AUXB_PER: rdata_nxt = {8'h00, aper_r[1]};
                OFF_AUXB_CMP: rdata_nxt = {8'h00, acmp_r[1]};
                OFF_AUXB_CNT: rdata_nxt = {8'h00, a_cnt[1]};
                OFF_STATUS: rdata_nxt = {6'h00, stat_r};
                OFF_MASK: rdata_nxt = {6'h00, mask_r};
                OFF_DMA_EN: rdata_nxt = {13'h0000, dmaen_r};
                default: begin
                    for (int i = 0; i < NCH; i++) begin
                        if (ADDR == OFF_CH_CTRL + 6'(i)) begin
                            rdata_nxt = {13'h0000, cctrl_r[i]};
                        end
                        if (ADDR == OFF_CH_VAL + 6'(i)) begin
                            rdata_nxt = cval_r[i];
                        end
                    end
                end
            endcase
            if (ADDR == OFF_STATUS) begin
                stat_nxt = '0;
            end
        end
        // a new event in the clearing cycle must survive the read
        stat_nxt = stat_nxt | ev_set;
        // one-cycle dma pulses: main overflow or any channel event, aux overflows
        dreq_nxt = dmaen_r & {a_ovf[1], a_ovf[0], m_ovf | (|(cap_edge | ch_match))};
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            mctrl_r <= 4'h0;
            mpre_r <= RST_ZERO16;
            mper_r <= RST_PER16;
            mcnt_r <= RST_ZERO16;
            for (int i = 0; i < NCH; i++) begin
                cctrl_r[i] <= 3'h0;
                cval_r[i] <= RST_ZERO16;
            end
            for (int j = 0; j < 2; j++) begin
                actrl_r[j] <= 1'b0;
                apre_r[j] <= RST_ZERO8;
                aper_r[j] <= RST_PER8;
                acmp_r[j] <= RST_ZERO8;
            end
            stat_r <= '0;
            mask_r <= '0;
            dmaen_r <= 3'h0;
            rdata_r <= RST_ZERO16;
            chout_r <= '0;
            dreq_r <= 3'h0;
            cap_s1_r <= '0;
            cap_s2_r <= '0;
            cap_d_r <= '0;
            ev_s1_r <= 1'b0;
            ev_s2_r <= 1'b0;
            ev_d_r <= 1'b0;
        end else begin
            mctrl_r <= mctrl_nxt;
            mpre_r <= mpre_nxt;
            mper_r <= mper_nxt;
            mcnt_r <= mcnt_nxt;
            cctrl_r <= cctrl_nxt;
            cval_r <= cval_nxt;
            actrl_r <= actrl_nxt;
            apre_r <= apre_nxt;
            aper_r <= aper_nxt;
            acmp_r <= acmp_nxt;
            stat_r <= stat_nxt;
            mask_r <= mask_nxt;
            dmaen_r <= dmaen_nxt;
            rdata_r <= rdata_nxt;
            chout_r <= chout_nxt;
            dreq_r <= dreq_nxt;
            cap_s1_r <= CAP_IN;
            cap_s2_r <= cap_s1_r;
            cap_d_r <= cap_s2_r;
            ev_s1_r <= EVENT_IN;
            ev_s2_r <= ev_s1_r;
            ev_d_r <= ev_s2_r;
        end
    end

    // ************************************
    // outputs
    // ************************************
    assign RDATA = rdata_r;
    assign CH_OUT = chout_r;
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            CH_OE[i] = !cctrl_r[i][CC_MODE];
        end
    end
    assign AUXA_OUT = a_pwm[0];
    assign AUXB_OUT = a_pwm[1];
    assign IR_OUT = ir_mode && chout_r[0] && a_pwm[0];
    assign DMA_REQ = dreq_r;
    assign IRQ = |(stat_r & mask_r);
endmodule // gtimer_top

// file: verification/gtimer_top_properties.sv
// Purpose: port checker for the timer group
// Assumes: one clock, async active-high reset
// Notes: sees only the top ports
module gtimer_top_properties import gtimer_pkg::*; (
    input wire logic CLK,
    input wire logic RST,
    input wire logic [ADDR_W-1:0] ADDR,
    input wire logic [DATA_W-1:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [DATA_W-1:0] RDATA,
    input wire logic [NCH-1:0] CH_OUT,
    input wire logic [NCH-1:0] CH_OE,
    input wire logic AUXA_OUT,
    input wire logic IR_OUT,
    input wire logic [2:0] DMA_REQ,
    input wire logic IRQ
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    // ************************************
    // port relations
    // ************************************
    rdata_idle_a: assert property (!$past(RD) |-> RDATA == 16'h0000)
        else $error("read data outside read slot");
    unmapped_zero_a: assert property (RD && ADDR == 6'h3F |=> RDATA == 16'h0000)
        else $error("unmapped read not zero");
    mask_back_a: assert property ((WR && ADDR == OFF_MASK) ##1 (RD && ADDR == OFF_MASK)
        |=> RDATA[NSTAT-1:0] == $past(WDATA[NSTAT-1:0], 2)) else $error("mask readback wrong");
    irq_masked_a: assert property (WR && ADDR == OFF_MASK && WDATA == 16'h0000 |=> !IRQ)
        else $error("irq with empty mask");
    ir_gate_a: assert property (IR_OUT |-> CH_OUT[0] && AUXA_OUT)
        else $error("ir output not gated");
    ir_off_a: assert property (WR && ADDR == OFF_MAIN_CTRL && !WDATA[MC_IR] |=> !IR_OUT)
        else $error("ir output while ir mode off");
    // one cycle of grace: the pin register lags a mode change
    oe_pwm_a: assert property ((CH_OUT & ~CH_OE & ~$past(CH_OE)) == 5'h00)
        else $error("channel drives while in capture");
    oe_mode_a: assert property (WR && ADDR == OFF_CH_CTRL |=> CH_OE[0] == !$past(WDATA[CC_MODE]))
        else $error("output enable not from mode bit");
    dma_gate_a: assert property (WR && ADDR == OFF_DMA_EN && WDATA[2:0] == 3'h0
        |=> ##1 DMA_REQ == 3'h0) else $error("dma request while disabled");
    cover property (IR_OUT);
    cover property (DMA_REQ[2]);
    cover property (IRQ);
    cover property ($fell(CH_OE[2]));
endmodule // gtimer_top_properties

bind gtimer_top gtimer_top_properties u_gtimer_top_properties (.CLK(CLK), .RST(RST), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .CH_OUT(CH_OUT), .CH_OE(CH_OE),
    .AUXA_OUT(AUXA_OUT), .IR_OUT(IR_OUT), .DMA_REQ(DMA_REQ), .IRQ(IRQ));

// file: verification/gtimer_pins.sv
// Purpose: model of the external event and capture sources
// Assumes: pins are asynchronous to the timer clock
// Notes: pins move 3 ns after the edge, off the sampling instant
module gtimer_pins (
    input wire logic clk,
    input wire logic rst,
    input wire logic ev_req,
    input wire logic [4:0] cap_tog,
    output logic event_pin,
    output logic [4:0] cap_pins
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] hold_r;
    logic [4:0] cap_r;
    // event held 3 clocks so the two-flop sync cannot miss it
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            hold_r <= 2'h0;
            cap_r <= 5'h00;
        end else begin
            hold_r <= ev_req ? 2'h3 : (hold_r != 2'h0 ? hold_r - 2'h1 : 2'h0);
            cap_r <= cap_r ^ cap_tog;
        end
    end
    assign #3 event_pin = (hold_r != 2'h0);
    assign #3 cap_pins = cap_r;
endmodule // gtimer_pins

// file: verification/gtimer_top_tb.sv
// Purpose: self-checking bench for the timer group
// Assumes: register port with read data one cycle after the strobe
// Notes: all windows span whole periods so phase does not matter
module gtimer_top_tb import gtimer_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic CLK;
    logic RST = 1'b1;
    logic [ADDR_W-1:0] ADDR = 6'h00;
    logic [DATA_W-1:0] WDATA = 16'h0000;
    logic WR = 1'b0;
    logic RD = 1'b0;
    logic ev_req = 1'b0;
    logic [4:0] cap_tog = 5'h00;
    logic [DATA_W-1:0] RDATA;
    logic EVENT_IN;
    logic [NCH-1:0] CAP_IN, CH_OUT, CH_OE;
    logic AUXA_OUT, AUXB_OUT, IR_OUT, IRQ;
    logic [2:0] DMA_REQ;
    logic [15:0] v, c1, c2;
    int bad_count = 0;
    int checked = 0;
    int cyc = 0;
    int h;
    wire [7:0] mon = {DMA_REQ[0], DMA_REQ[1], IRQ, DMA_REQ[2], IR_OUT, AUXB_OUT, AUXA_OUT, CH_OUT[1]};
    gtimer_top u_gtimer_top (.CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .EVENT_IN(EVENT_IN), .CAP_IN(CAP_IN), .CH_OUT(CH_OUT), .CH_OE(CH_OE),
        .AUXA_OUT(AUXA_OUT), .AUXB_OUT(AUXB_OUT), .IR_OUT(IR_OUT), .DMA_REQ(DMA_REQ), .IRQ(IRQ));
    gtimer_pins u_gtimer_pins (.clk(CLK), .rst(RST), .ev_req(ev_req), .cap_tog(cap_tog),
        .event_pin(EVENT_IN), .cap_pins(CAP_IN));
    initial begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end
    // ************************************
    // shared tasks
    // ************************************
    task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task wr(input logic [5:0] a, input logic [15:0] d);
        @(posedge CLK);
        WR <= 1'b1;
        ADDR <= a;
        WDATA <= d;
        @(posedge CLK);
        WR <= 1'b0;
    endtask
    task rd(input logic [5:0] a, output logic [15:0] d);
        @(posedge CLK);
        RD <= 1'b1;
        ADDR <= a;
        @(posedge CLK);
        RD <= 1'b0;
        #1 d = RDATA;
    endtask
    task hi_count(input int b, input int n, output int hc);
        hc = 0;
        repeat (n) begin
            @(posedge CLK);
            #1 hc += int'(mon[b] === 1'b1);
        end
    endtask
    task pulse(input int ch);
        @(posedge CLK);
        if (ch < 0) ev_req <= 1'b1;
        else cap_tog <= 5'h01 << ch;
        @(posedge CLK);
        ev_req <= 1'b0;
        cap_tog <= 5'h00;
        repeat (8) @(posedge CLK);
    endtask
    // ************************************
    // scenarios
    // ************************************
    task t_reset;
        rd(OFF_MAIN_PER, v); check("main period", v, 16'hFFFF);
        rd(OFF_AUXA_PER, v); check("aux period", v, 16'h00FF);
        // run bit set with the stop mode: counter must stay at zero
        wr(OFF_MAIN_CTRL, 16'h0001);
        wr(OFF_MAIN_CNT, 16'h0005);
        rd(OFF_MAIN_CNT, v); check("main count", v, 16'h0000);
        wr(OFF_MAIN_CTRL, 16'h0000);
        rd(6'h3F, v); check("unmapped", v, 16'h0000);
        check("output enables", {11'h000, CH_OE}, 16'h001F);
    endtask
    task t_ovf;
        wr(OFF_MASK, 16'h0000);
        wr(OFF_MAIN_PRE, 16'h0001);
        wr(OFF_MAIN_PER, 16'h0003);
        wr(OFF_MAIN_CTRL, 16'h0003);
        repeat (12) @(posedge CLK);
        #1 check("irq masked", {15'h0000, IRQ}, 16'h0000);
        // mask write and read back with no gap between the strobes
        @(posedge CLK);
        WR <= 1'b1;
        ADDR <= OFF_MASK;
        WDATA <= 16'h0001;
        @(posedge CLK);
        WR <= 1'b0;
        RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        #1 check("mask readback", RDATA, 16'h0001);
        check("irq", {15'h0000, IRQ}, 16'h0001);
        wr(OFF_MAIN_CTRL, 16'h0000);
        rd(OFF_STATUS, v); check("overflow flag", v & 16'h0001, 16'h0001);
        rd(OFF_STATUS, v); check("status cleared", v, 16'h0000);
        check("irq cleared", {15'h0000, IRQ}, 16'h0000);
        wr(OFF_MASK, 16'h0000);
    endtask
    task t_pwm;
        wr(OFF_CH_VAL + 6'h01, 16'h0002);
        wr(OFF_MAIN_PRE, 16'h0000);
        wr(OFF_MAIN_PER, 16'h0004);
        wr(OFF_MAIN_CTRL, 16'h0007);
        wr(OFF_AUXB_PER, 16'h0004);
        wr(OFF_AUXB_CMP, 16'h0003);
        wr(OFF_DMA_EN, 16'h0004);
        wr(OFF_AUXB_CTRL, 16'h0001);
        repeat (10) @(posedge CLK);
        hi_count(0, 20, h); check("channel pwm", 16'(h), 16'h0008);
        hi_count(2, 20, h); check("aux pwm", 16'(h), 16'h000C);
        hi_count(4, 20, h); check("aux dma", 16'(h), 16'h0004);
        wr(OFF_DMA_EN, 16'h0000);
        hi_count(4, 20, h); check("dma off", 16'(h), 16'h0000);
        wr(OFF_AUXB_CTRL, 16'h0000);
        wr(OFF_MAIN_CTRL, 16'h0000);
    endtask
    task t_ir;
        wr(OFF_AUXA_PER, 16'h0003);
        wr(OFF_AUXA_CMP, 16'h0002);
        wr(OFF_AUXA_CTRL, 16'h0001);
        wr(OFF_CH_VAL, 16'h0001);
        wr(OFF_MAIN_PER, 16'h0001);
        wr(OFF_MAIN_CTRL, 16'h000F);
        wr(OFF_DMA_EN, 16'h0003);
        repeat (20) @(posedge CLK);
        hi_count(3, 32, h); check("ir carrier", 16'(h), 16'h0008);
        hi_count(1, 32, h); check("aux a pwm", 16'(h), 16'h0010);
        // one aux A overflow per 4 clocks, one main tick per aux A period
        hi_count(6, 32, h); check("aux a dma", 16'(h), 16'h0008);
        hi_count(7, 32, h); check("main dma", 16'(h), 16'h0008);
        wr(OFF_DMA_EN, 16'h0000);
        wr(OFF_MAIN_CTRL, 16'h0007);
        #1 check("ir off", {15'h0000, IR_OUT}, 16'h0000);
        wr(OFF_MAIN_CTRL, 16'h0000);
        wr(OFF_AUXA_CTRL, 16'h0000);
    endtask
    task t_event;
        wr(OFF_MAIN_PER, 16'hFFFF);
        wr(OFF_MAIN_CTRL, 16'h0005);
        repeat (3) pulse(-1);
        rd(OFF_MAIN_CNT, v); check("event count", v, 16'h0003);
        wr(OFF_MAIN_CTRL, 16'h0000);
    endtask
    task t_capture;
        wr(OFF_CH_CTRL + 6'h02, 16'h0003);
        #1 check("capture oe", {15'h0000, CH_OE[2]}, 16'h0000);
        wr(OFF_MAIN_CTRL, 16'h0003);
        rd(OFF_STATUS, v);
        rd(OFF_MAIN_CNT, c1);
        pulse(2);
        rd(OFF_MAIN_CNT, c2);
        rd(OFF_CH_VAL + 6'h02, v);
        check("capture window", {15'h0000, v > c1 && v < c2}, 16'h0001);
        rd(OFF_STATUS, c1); check("capture flag", c1 & 16'h0008, 16'h0008);
        // falling edge must not capture: only rising is selected
        pulse(2);
        rd(OFF_CH_VAL + 6'h02, c2); check("falling ignored", c2, v);
        // falling-only select: next rise is ignored, the fall after it captures
        wr(OFF_CH_CTRL + 6'h02, 16'h0005);
        pulse(2);
        rd(OFF_CH_VAL + 6'h02, c2); check("rise ignored", c2, v);
        rd(OFF_MAIN_CNT, c1);
        pulse(2);
        rd(OFF_CH_VAL + 6'h02, c2); check("fall capture", {15'h0000, c2 > c1}, 16'h0001);
        wr(OFF_MAIN_CTRL, 16'h0000);
        wr(OFF_CH_CTRL + 6'h02, 16'h0000);
    endtask
    always @(posedge CLK) begin
        cyc++;
        if (cyc == 5000) begin
            bad_count++;
            give_verdict;
        end
    end
    initial begin
        repeat (10) @(posedge CLK);
        RST <= 1'b0;
        t_reset;
        t_ovf;
        t_pwm;
        t_ir;
        t_event;
        t_capture;
        give_verdict;
    end
endmodule // gtimer_top_tb
